// File: rtl/umda_dev.sv
// Packing logic between the holding ports and the transmit/receive FIFOs.
// Assumes the serial engine pops tx characters and pushes rx characters
// one per cycle through the serial engine side ports.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module umda_dev #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus side
  umda_if.dev bus,
  // Serial engine side
  input wire logic tx_pop,
  output logic [umda_pkg::CHAR_W-1:0] tx_char,
  output logic tx_char_valid,
  input wire logic rx_push,
  input wire logic [umda_pkg::CHAR_W-1:0] rx_char
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [umda_pkg::CHAR_W-1:0] txm_q [DEPTH];
  logic [umda_pkg::CHAR_W-1:0] txm_d [DEPTH];
  logic [umda_pkg::CHAR_W-1:0] rxm_q [DEPTH];
  logic [umda_pkg::CHAR_W-1:0] rxm_d [DEPTH];
  logic [AW-1:0] txw_q, txw_d, txr_q, txr_d;
  logic [AW-1:0] rxw_q, rxw_d, rxr_q, rxr_d;
  logic [CW-1:0] txc_q, txc_d, rxc_q, rxc_d;
  logic [umda_pkg::BUS_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic tx_space_flag_q, tx_space_flag_d, rx_avail_flag_q, rx_avail_flag_d;
  logic txerr_q, txerr_d, rxerr_q, rxerr_d;
  logic [umda_pkg::CHAR_W-1:0] txo_q, txo_d;
  logic txv_q, txv_d;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic packed_ok;
    logic [2:0] wn, rn;
    logic [CW-1:0] tx_free, tx_cnt, rx_cnt;
    logic tx_ok, rx_ok, pop, push;
    packed_ok = 1'b0;
    wn = umda_pkg::CNT_ONE;
    rn = umda_pkg::CNT_ONE;
    tx_free = '0;
    tx_cnt = '0;
    rx_cnt = '0;
    tx_ok = 1'b0;
    rx_ok = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    txm_d = txm_q;
    rxm_d = rxm_q;
    txw_d = txw_q;
    txr_d = txr_q;
    rxw_d = rxw_q;
    rxr_d = rxr_q;
    txerr_d = txerr_q & ~bus.err_clr;
    rxerr_d = rxerr_q & ~bus.err_clr;
    rdata_d = '0;
    rvalid_d = 1'b0;
    // Packed mode is simply ignored under nine-bit or LIN operation
    packed_ok = ~bus.nine_bit_char_select & ~bus.lin_mode;
    if (packed_ok && bus.tx_ready_threshold_field != umda_pkg::THR_SINGLE)
      wn = umda_pkg::size_count(bus.tx_size);
    if (packed_ok && bus.rx_ready_threshold_field != umda_pkg::THR_SINGLE)
      rn = umda_pkg::size_count(bus.rx_size);

    // Transmit: engine pop first, then bus write against the space held before the pop
    pop = tx_pop && txc_q != '0;
    txo_d = txo_q;
    txv_d = 1'b0;
    if (pop)
    begin
      txo_d = txm_q[txr_q];
      txv_d = 1'b1;
      txr_d = txr_q + AW'(1);
    end
    tx_cnt = txc_q - (pop ? CW'(1) : CW'(0));
    // Room is judged before this cycle's pop, so a pop never makes
    // room for a write landing in the same cycle
    tx_free = DEPTH_C - txc_q;
    tx_ok = CW'(wn) <= tx_free;
    if (bus.tx_wr)
    begin
      if (tx_ok)
      begin
        for (int i = 0; i < umda_pkg::MAX_PACK; i++)
          if (i < int'(wn))
            txm_d[AW'(txw_q + AW'(i))] =
              bus.tx_wdata[i*umda_pkg::CHAR_W +: umda_pkg::CHAR_W];
        txw_d = txw_q + AW'(wn);
        tx_cnt = tx_cnt + CW'(wn);
      end
      else
        txerr_d = 1'b1;
    end
    txc_d = tx_cnt;

    // Receive: bus read against current content, then engine push
    rx_cnt = rxc_q;
    rx_ok = CW'(rn) <= rxc_q;
    if (bus.rx_rd)
    begin
      rvalid_d = 1'b1;
      if (rx_ok)
      begin
        for (int i = 0; i < umda_pkg::MAX_PACK; i++)
          if (i < int'(rn))
            rdata_d[i*umda_pkg::CHAR_W +: umda_pkg::CHAR_W] =
              rxm_q[AW'(rxr_q + AW'(i))];
        rxr_d = rxr_q + AW'(rn);
        rx_cnt = rx_cnt - CW'(rn);
      end
      else
        rxerr_d = 1'b1;
    end
    push = rx_push && rx_cnt != DEPTH_C;
    if (push)
    begin
      rxm_d[rxw_q] = rx_char;
      rxw_d = rxw_q + AW'(1);
      rx_cnt = rx_cnt + CW'(1);
    end
    rxc_d = rx_cnt;

    // Flags follow the updated counts; a threshold change reaches them
    // one cycle late, so a host may still act on the old flag
    tx_space_flag_d = (DEPTH_C - txc_d) >=
      CW'(umda_pkg::thr_count(bus.tx_ready_threshold_field));
    rx_avail_flag_d = rxc_d >=
      CW'(umda_pkg::thr_count(bus.rx_ready_threshold_field));
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txw_q <= '0;
      txr_q <= '0;
      rxw_q <= '0;
      rxr_q <= '0;
      txc_q <= '0;
      rxc_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      tx_space_flag_q <= 1'b0;
      rx_avail_flag_q <= 1'b0;
      txerr_q <= 1'b0;
      rxerr_q <= 1'b0;
      txo_q <= '0;
      txv_q <= 1'b0;
    end
    else
    begin
      txw_q <= txw_d;
      txr_q <= txr_d;
      rxw_q <= rxw_d;
      rxr_q <= rxr_d;
      txc_q <= txc_d;
      rxc_q <= rxc_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      tx_space_flag_q <= tx_space_flag_d;
      rx_avail_flag_q <= rx_avail_flag_d;
      txerr_q <= txerr_d;
      rxerr_q <= rxerr_d;
      txo_q <= txo_d;
      txv_q <= txv_d;
    end
  end

  // Storage holds no reset so it maps onto plain memory
  always_ff @(posedge core_clk)
  begin
    txm_q <= txm_d;
    rxm_q <= rxm_d;
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus.rx_rdata = rdata_q;
  assign bus.rx_rvalid = rvalid_q;
  assign bus.tx_space_flag = tx_space_flag_q;
  assign bus.rx_avail_flag = rx_avail_flag_q;
  assign bus.tx_fifo_pointer_error = txerr_q;
  assign bus.rx_fifo_pointer_error = rxerr_q;
  assign tx_char = txo_q;
  assign tx_char_valid = txv_q;
endmodule

// File: rtl/umda_pkg.sv
// Package for the packed-access FIFO face of a serial port.
// Assumes an 8-bit character path and a 32-bit peripheral data bus.
package umda_pkg;

  localparam int CHAR_W = 8;
  localparam int BUS_W = 32;
  localparam int MAX_PACK = 4;

  // Threshold field: 0 single, 1 two characters, 2 four characters
  localparam logic [1:0] THR_SINGLE = 2'h0;
  localparam logic [1:0] THR_TWO = 2'h1;
  localparam logic [1:0] THR_FOUR = 2'h2;

  // Access size codes on the holding ports
  typedef enum logic [1:0] {
    UMDA_SZ_BYTE = 2'h0,
    UMDA_SZ_HALF = 2'h1,
    UMDA_SZ_WORD = 2'h2
  } umda_size_t;

  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  // Threshold field to required character count
  function automatic logic [2:0] thr_count(input logic [1:0] thr);
    logic [2:0] c;
    c = CNT_ONE;
    if (thr == THR_TWO)
      c = CNT_TWO;
    else if (thr >= THR_FOUR)
      c = CNT_FOUR;
    return c;
  endfunction

  // Access size to character count
  function automatic logic [2:0] size_count(input umda_size_t sz);
    logic [2:0] c;
    c = CNT_ONE;
    if (sz == UMDA_SZ_HALF)
      c = CNT_TWO;
    else if (sz == UMDA_SZ_WORD)
      c = CNT_FOUR;
    return c;
  endfunction

endpackage

// File: rtl/umda_if.sv
// Interface joining the bus master end and the FIFO packing end.
// Assumes one clock; all signals sampled on its rising edge.
`timescale 1ns/1ps
interface umda_if;
  logic tx_wr;
  umda_pkg::umda_size_t tx_size;
  logic [umda_pkg::BUS_W-1:0] tx_wdata;
  logic rx_rd;
  umda_pkg::umda_size_t rx_size;
  logic [umda_pkg::BUS_W-1:0] rx_rdata;
  logic rx_rvalid;
  logic [1:0] tx_ready_threshold_field;
  logic [1:0] rx_ready_threshold_field;
  logic nine_bit_char_select;
  logic lin_mode;
  logic tx_space_flag;
  logic rx_avail_flag;
  logic tx_fifo_pointer_error;
  logic rx_fifo_pointer_error;
  logic err_clr;

  modport dev (
    input tx_wr, tx_size, tx_wdata, rx_rd, rx_size,
    input tx_ready_threshold_field, rx_ready_threshold_field,
    input nine_bit_char_select, lin_mode, err_clr,
    output rx_rdata, rx_rvalid, tx_space_flag, rx_avail_flag,
    output tx_fifo_pointer_error, rx_fifo_pointer_error
  );
  modport host (
    output tx_wr, tx_size, tx_wdata, rx_rd, rx_size,
    output tx_ready_threshold_field, rx_ready_threshold_field,
    output nine_bit_char_select, lin_mode, err_clr,
    input rx_rdata, rx_rvalid, tx_space_flag, rx_avail_flag,
    input tx_fifo_pointer_error, rx_fifo_pointer_error
  );
endinterface

// File: rtl/umda_host.sv
// Bus master end: turns user requests into holding-port accesses.
// Assumes the user holds a request until it sees the matching done pulse.
`timescale 1ns/1ps
module umda_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to the packing end
  umda_if.host bus,
  // User configuration
  input wire logic [1:0] cfg_tx_thr,
  input wire logic [1:0] cfg_rx_thr,
  input wire logic cfg_nine_bit,
  input wire logic cfg_lin,
  input wire logic cfg_err_clr,
  // User requests
  input wire logic wr_req,
  input wire logic [umda_pkg::BUS_W-1:0] wr_data,
  input wire logic rd_req,
  // User answers
  output logic wr_done,
  output logic rd_done,
  output logic [umda_pkg::BUS_W-1:0] rd_data,
  output logic tx_err,
  output logic rx_err
);
  logic [1:0] txt_q, txt_d, rxt_q, rxt_d;
  logic nine_q, nine_d, lin_q, lin_d, clr_q, clr_d;
  logic wr_q, wr_d, rd_q, rd_d, pend_q, pend_d;
  umda_pkg::umda_size_t wsz_q, wsz_d, rsz_q, rsz_d;
  logic [umda_pkg::BUS_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic wdone_q, wdone_d, rdone_q, rdone_d;

  // Size follows threshold; single mode uses byte access
  function automatic umda_pkg::umda_size_t thr_size(input logic [1:0] t);
    umda_pkg::umda_size_t s;
    s = umda_pkg::UMDA_SZ_BYTE;
    if (t == umda_pkg::THR_TWO)
      s = umda_pkg::UMDA_SZ_HALF;
    else if (t >= umda_pkg::THR_FOUR)
      s = umda_pkg::UMDA_SZ_WORD;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic packed_ok;
    packed_ok = ~cfg_nine_bit & ~cfg_lin;
    // Thresholds forced to single in nine-bit or LIN mode
    txt_d = packed_ok ? cfg_tx_thr : umda_pkg::THR_SINGLE;
    rxt_d = packed_ok ? cfg_rx_thr : umda_pkg::THR_SINGLE;
    nine_d = cfg_nine_bit;
    lin_d = cfg_lin;
    clr_d = cfg_err_clr;
    wr_d = 1'b0;
    rd_d = 1'b0;
    // Size tracks the field value going out in the same cycle
    wsz_d = thr_size(txt_d);
    rsz_d = thr_size(rxt_d);
    wdat_d = wr_data;
    rdat_d = rdat_q;
    wdone_d = 1'b0;
    rdone_d = 1'b0;
    pend_d = pend_q;
    // Issue only while the ready flag says the packed access fits
    if (wr_req && !wr_q && !wdone_q && bus.tx_space_flag)
    begin
      wr_d = 1'b1;
      wdone_d = 1'b1;
    end
    if (rd_req && !rd_q && !pend_q && !rdone_q && bus.rx_avail_flag)
    begin
      rd_d = 1'b1;
      pend_d = 1'b1;
    end
    if (bus.rx_rvalid)
    begin
      rdat_d = bus.rx_rdata;
      rdone_d = 1'b1;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txt_q <= umda_pkg::THR_SINGLE;
      rxt_q <= umda_pkg::THR_SINGLE;
      nine_q <= 1'b0;
      lin_q <= 1'b0;
      clr_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pend_q <= 1'b0;
      wsz_q <= umda_pkg::UMDA_SZ_BYTE;
      rsz_q <= umda_pkg::UMDA_SZ_BYTE;
      wdat_q <= '0;
      rdat_q <= '0;
      wdone_q <= 1'b0;
      rdone_q <= 1'b0;
    end
    else
    begin
      txt_q <= txt_d;
      rxt_q <= rxt_d;
      nine_q <= nine_d;
      lin_q <= lin_d;
      clr_q <= clr_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      pend_q <= pend_d;
      wsz_q <= wsz_d;
      rsz_q <= rsz_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      wdone_q <= wdone_d;
      rdone_q <= rdone_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus.tx_ready_threshold_field = txt_q;
  assign bus.rx_ready_threshold_field = rxt_q;
  assign bus.nine_bit_char_select = nine_q;
  assign bus.lin_mode = lin_q;
  assign bus.err_clr = clr_q;
  assign bus.tx_wr = wr_q;
  assign bus.tx_size = wsz_q;
  assign bus.tx_wdata = wdat_q;
  assign bus.rx_rd = rd_q;
  assign bus.rx_size = rsz_q;
  assign wr_done = wdone_q;
  assign rd_done = rdone_q;
  assign rd_data = rdat_q;
  assign tx_err = bus.tx_fifo_pointer_error;
  assign rx_err = bus.rx_fifo_pointer_error;
endmodule

// File: testbench/umda_properties.sv
// Checker for the link between the bus end and the packing end.
// Assumes one clock domain and the signal set of umda_if.
`timescale 1ns/1ps
module umda_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic tx_wr,
  input wire logic rx_rd,
  input umda_pkg::umda_size_t rx_size,
  input wire logic [31:0] rx_rdata,
  input wire logic rx_rvalid,
  input wire logic nine_bit_char_select,
  input wire logic tx_fifo_pointer_error,
  input wire logic rx_fifo_pointer_error,
  input wire logic err_clr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (rx_rd |=> rx_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (rx_rvalid |-> $past(rx_rd))
    else $error("read data without a read");
  rvalid_pulse_a: assert property (rx_rvalid && !rx_rd |=> !rx_rvalid)
    else $error("read answer held too long");
  byte_lane_a: assert property (
    rx_rvalid && $past(rx_size) == umda_pkg::UMDA_SZ_BYTE
    |-> rx_rdata[31:8] == '0)
    else $error("byte read not right-aligned");
  half_lane_a: assert property (
    rx_rvalid && $past(rx_size) == umda_pkg::UMDA_SZ_HALF
    |-> rx_rdata[31:16] == '0)
    else $error("halfword read not right-aligned");
  nine_single_a: assert property (
    rx_rvalid && $past(nine_bit_char_select)
    |-> rx_rdata[31:8] == '0)
    else $error("packed read under nine-bit mode");
  tx_err_cause_a: assert property (
    $rose(tx_fifo_pointer_error) |-> $past(tx_wr))
    else $error("tx error without a write");
  rx_err_cause_a: assert property (
    $rose(rx_fifo_pointer_error) |-> $past(rx_rd))
    else $error("rx error without a read");
  err_sticky_a: assert property (
    tx_fifo_pointer_error && !err_clr |=> tx_fifo_pointer_error)
    else $error("tx error lost");
  err_clear_a: assert property (
    err_clr && !tx_wr && !rx_rd
    |=> !tx_fifo_pointer_error && !rx_fifo_pointer_error)
    else $error("error flags not cleared");

  word_read_c: cover property (rx_rvalid &&
    $past(rx_size) == umda_pkg::UMDA_SZ_WORD);
  half_read_c: cover property (rx_rvalid &&
    $past(rx_size) == umda_pkg::UMDA_SZ_HALF);
  nine_read_c: cover property (rx_rvalid && nine_bit_char_select);
  tx_err_c: cover property ($rose(tx_fifo_pointer_error));
endmodule

// File: testbench/umda_bench.sv
// Self-checking bench: host and packing end joined, plus a second packing
// end driven directly to provoke pointer errors. Assumes DEPTH of 4.
`timescale 1ns/1ps
module umda_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] cfg_thr = 2'h0;
  logic cfg_nine = 1'b0;
  logic cfg_lin = 1'b0;
  logic cfg_err_clr = 1'b0;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic tx_pop = 1'b0;
  logic rx_push = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic [7:0] rx_char = 8'h0;
  logic [31:0] rd_data;
  logic [7:0] tx_char;
  logic wr_done, rd_done, tx_err, rx_err, tx_char_valid;
  logic [15:0] lfsr_q = 16'h518F;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int err_total = 0;
  int n_tests = 0;

  always #50 core_clk = ~core_clk;

  umda_if bus();
  umda_if bus2();

  umda_host i_umda_host (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
    .cfg_tx_thr(cfg_thr), .cfg_rx_thr(cfg_thr), .cfg_nine_bit(cfg_nine),
    .cfg_lin(cfg_lin), .cfg_err_clr(cfg_err_clr), .wr_req(wr_req),
    .wr_data(wr_data), .rd_req(rd_req), .wr_done(wr_done),
    .rd_done(rd_done), .rd_data(rd_data), .tx_err(tx_err), .rx_err(rx_err));
  umda_dev #(.DEPTH(4)) i_umda_dev (.core_clk(core_clk), .rst_n(rst_n),
    .bus(bus), .tx_pop(tx_pop), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .rx_push(rx_push), .rx_char(rx_char));
  // Engine side idle: this end only sees bus-side misuse
  umda_dev #(.DEPTH(4)) i_umda_dev_b (.core_clk(core_clk), .rst_n(rst_n),
    .bus(bus2), .tx_pop(1'b0), .tx_char(), .tx_char_valid(),
    .rx_push(1'b0), .rx_char(8'h00));
  umda_properties i_umda_properties (.core_clk(core_clk), .rst_n(rst_n),
    .tx_wr(bus.tx_wr), .rx_rd(bus.rx_rd), .rx_size(bus.rx_size),
    .rx_rdata(bus.rx_rdata), .rx_rvalid(bus.rx_rvalid),
    .nine_bit_char_select(bus.nine_bit_char_select),
    .tx_fifo_pointer_error(bus.tx_fifo_pointer_error),
    .rx_fifo_pointer_error(bus.rx_fifo_pointer_error),
    .err_clr(bus.err_clr));

  ////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge core_clk);
    #10;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [7:0] v);
    lfsr_q = lfsr_next(lfsr_q);
    v = lfsr_q[7:0];
  endtask

  // Characters per access; nine-bit and LIN force single characters
  function automatic int cnt(input int thr, input logic nine, input logic lin);
    if (nine || lin || thr == 0)
      return 1;
    return (thr == 1) ? 2 : 4;
  endfunction

  task automatic do_write(input logic [31:0] d, input int n);
    int k;
    wr_req = 1'b1;
    wr_data = d;
    for (k = 0; k < 40 && wr_done !== 1'b1; k++)
      step;
    chk(32'(wr_done), 32'h1, "write not done");
    wr_req = 1'b0;
    for (k = 0; k < n; k++)
      txq.push_back(d[8*k +: 8]);
  endtask

  task automatic do_read(input int n);
    int k;
    logic [31:0] e;
    rd_req = 1'b1;
    for (k = 0; k < 40 && rd_done !== 1'b1; k++)
      step;
    rd_req = 1'b0;
    e = 32'h0;
    for (k = 0; k < n; k++)
      e[8*k +: 8] = rxq.pop_front();
    chk(rd_data, e, "read data");
  endtask

  // Valid stands for one cycle only, so it is looked at right away;
  // the trailing step keeps two pops from touching one time step
  task automatic pop_char;
    tx_pop = 1'b1;
    step;
    tx_pop = 1'b0;
    chk(32'(tx_char_valid), 32'h1, "tx character valid");
    chk(32'(tx_char), 32'(txq.pop_front()), "tx character");
    step;
  endtask

  task automatic push_char;
    logic [7:0] v;
    rnd(v);
    rx_push = 1'b1;
    rx_char = v;
    rxq.push_back(v);
    step;
    rx_push = 1'b0;
    step;
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    test_done;
  end

  initial
  begin
    int m, n, k;
    logic [7:0] b0, b1, b2, b3;
    bus2.tx_wr = 1'b0;
    bus2.rx_rd = 1'b0;
    bus2.tx_size = umda_pkg::UMDA_SZ_WORD;
    bus2.rx_size = umda_pkg::UMDA_SZ_WORD;
    bus2.tx_wdata = 32'hA5A5A5A5;
    bus2.tx_ready_threshold_field = 2'h2;
    bus2.rx_ready_threshold_field = 2'h2;
    bus2.nine_bit_char_select = 1'b0;
    bus2.lin_mode = 1'b0;
    bus2.err_clr = 1'b0;
    repeat (4) @(posedge core_clk);
    #10 rst_n = 1'b1;
    chk({30'h0, tx_err, rx_err}, 32'h0, "error flags after reset");
    step;
    for (m = 0; m < 5; m++)
    begin
      cfg_thr = (m == 0) ? 2'h0 : (m == 1) ? 2'h1 : 2'h2;
      cfg_nine = (m == 3);
      cfg_lin = (m == 4);
      n = cnt(int'(cfg_thr), cfg_nine, cfg_lin);
      repeat (3) step;
      rnd(b0);
      rnd(b1);
      rnd(b2);
      rnd(b3);
      do_write({b3, b2, b1, b0}, n);
      step;
      step;
      chk(32'(bus.tx_space_flag), 32'(4 - n >= n), "tx ready");
      for (k = 0; k < n; k++)
        pop_char;
      for (k = 0; k < n - 1; k++)
        push_char;
      step;
      chk(32'(bus.rx_avail_flag), 32'h0, "rx ready early");
      push_char;
      step;
      chk(32'(bus.rx_avail_flag), 32'h1, "rx ready");
      do_read(n);
      $display("test %0d done", m);
    end
    // Threshold raised just before a request: the flag still shows the
    // single-character room, so the packed access is refused and sets the pointer error
    cfg_thr = 2'h0;
    cfg_lin = 1'b0;
    cfg_nine = 1'b0;
    repeat (3) step;
    for (k = 0; k < 3; k++)
    begin
      rnd(b0);
      do_write({24'h0, b0}, 1);
      step;
    end
    push_char;
    step;
    cfg_thr = 2'h2;
    step;
    do_write(32'hFFFFFFFF, 0);
    step;
    chk(32'(tx_err), 32'h1, "packed write past free space");
    cfg_thr = 2'h0;
    repeat (3) step;
    cfg_thr = 2'h2;
    step;
    do_read(0);
    chk(32'(rx_err), 32'h1, "packed read past content");
    for (k = 0; k < 3; k++)
      pop_char;
    $display("test threshold switch done");
    cfg_err_clr = 1'b1;
    step;
    cfg_err_clr = 1'b0;
    step;
    chk({30'h0, tx_err, rx_err}, 32'h0, "host error clear");
    // Second word overfills a four-deep FIFO, then read from empty
    bus2.tx_wr = 1'b1;
    step;
    step;
    bus2.tx_wr = 1'b0;
    step;
    chk(32'(bus2.tx_fifo_pointer_error), 32'h1, "tx overfill");
    chk(32'(bus2.tx_space_flag), 32'h0, "tx ready when full");
    bus2.rx_rd = 1'b1;
    step;
    bus2.rx_rd = 1'b0;
    chk(32'(bus2.rx_rvalid), 32'h1, "over-read answer");
    chk(bus2.rx_rdata, 32'h0, "over-read data");
    step;
    chk(32'(bus2.rx_fifo_pointer_error), 32'h1, "rx over-read");
    bus2.err_clr = 1'b1;
    step;
    step;
    bus2.err_clr = 1'b0;
    chk({30'h0, bus2.tx_fifo_pointer_error, bus2.rx_fifo_pointer_error},
        32'h0, "error clear");
    $display("test error paths done");
    test_done;
  end
endmodule
